// file: verilog/acc_ctrl.sv
/*
  acc_ctrl: control and configuration of a SAR converter, Wishbone classic slave.
  Assumes timer overflow strobes, core done/window strobes and the SAR clock
  enable inputs are synchronous to clk_i; the external start pin is asynchronous.
*/
// Function
// - converter_on at bit 7 shuts the converter down when 0 and enables it when 1.
// - burst_run_enable at bit 6 selects burst operation when 1, single when 0.
// - conversion_done_flag at bit 5 is set when a conversion or burst ends and only software clears it.
// - window_hit_flag at bit 3 is set on a window hit and only software clears it.
// - writing 1 to convert_busy_trigger at bit 4 starts a conversion when the source is 000.
// - the start source field picks software, timer 0, timer 2, timer 3 or pin rising edge; 101-111 start nothing.
// - the divider field at bits 7:3 gives a SAR clock of input clock over field plus one.
// - the converter input clock is the system clock without burst and the fast oscillator with burst.
// - eight_bit_select at bit 2 selects 8-bit mode when 1 and 10/12-bit when 0.
// - track mode 0 converts at once after the start, mode 1 tracks 4 SAR clocks first.
// - gain_select at bit 0 of configuration sets gain 0.5 when 0 and 1 when 1.
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl #(
  parameter int DIV_W = 5
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [9:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   timer0_ovf_i,
  input  wire logic                   timer2_ovf_i,
  input  wire logic                   timer3_ovf_i,
  input  wire logic                   external_start_pin_i,
  input  wire logic                   system_clock_source_sar_tick_i,
  input  wire logic                   hfosc_sar_tick_i,
  input  wire logic                   core_done_i,
  input  wire logic                   core_window_hit_i,
  output acc_pkg::acc_core_cfg_t      core_cfg_o,
  output logic      [DIV_W-1:0]       sar_clock_divider_o,
  output logic                        sar_clk_en_o,
  output logic                        core_start_o,
  output logic                        tracking_o,
  output logic                        irq_o
);
  // the register map holds a five-bit divider field; no other width is served
  if (DIV_W != 5) begin : g_div_w_check
    $error("acc_ctrl: DIV_W must be 5");
  end

  // register state
  logic [7:0] ctrl_one, next_ctrl_one;
  logic [7:0] ctrl_two, next_ctrl_two;
  logic [7:0] config_r, next_config_r;
  logic [1:0] irq_mask, next_irq_mask;
  logic [1:0] irq_stat, next_irq_stat;
  logic       ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic       irq, next_irq;
  // start and conversion sequencing state
  acc_pkg::acc_state_t state, next_state;
  logic [DIV_W-1:0] div_cnt, next_div_cnt;
  logic       sar_en, next_sar_en;
  logic [2:0] trk_cnt, next_trk_cnt;
  logic       start_q, next_start_q;
  logic       tracking, next_tracking;
  logic       pin_s1, pin_s2, pin_s3;

  // register index of a word address
  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    return a[9:2] == idx;
  endfunction

  wire logic bus_req  = wb_cyc_i & wb_stb_i & ~ack;
  wire logic wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
  wire logic rd_req   = bus_req & ~wb_we_i;
  wire logic pin_rise = pin_s2 & ~pin_s3;

  // pick the trigger chosen by the source field
  logic trig;
  always_comb begin
    case (ctrl_one[acc_pkg::BIT_SRC_LO +: 3])
      acc_pkg::SRC_SOFT:   trig = wr_lane0 & hit(wb_adr_i, acc_pkg::IDX_CTRL_ONE)
                                  & wb_dat_i[acc_pkg::BIT_BUSY];
      acc_pkg::SRC_TMR0:   trig = timer0_ovf_i;
      acc_pkg::SRC_TMR2:   trig = timer2_ovf_i;
      acc_pkg::SRC_TMR3:   trig = timer3_ovf_i;
      acc_pkg::SRC_EXTPIN: trig = pin_rise;
      default:             trig = 1'b0;
    endcase
  end

  wire logic conv_on   = ctrl_one[acc_pkg::BIT_ON];
  wire logic burst_on  = ctrl_one[acc_pkg::BIT_BURST];
  wire logic start_ok  = trig & conv_on & (state == acc_pkg::ACC_IDLE);
  wire logic src_tick  = burst_on ? hfosc_sar_tick_i : system_clock_source_sar_tick_i;

  // next values of the registers and the bus answer
  always_comb begin
    next_ctrl_one = ctrl_one;
    next_ctrl_two = ctrl_two;
    next_config_r = config_r;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_ack      = bus_req;
    next_rdat     = 32'h0000_0000;
    if (wr_lane0 && hit(wb_adr_i, acc_pkg::IDX_CTRL_ONE)) begin
      next_ctrl_one = wb_dat_i[7:0];
      next_ctrl_one[acc_pkg::BIT_BUSY] = ctrl_one[acc_pkg::BIT_BUSY];
    end
    if (wr_lane0 && hit(wb_adr_i, acc_pkg::IDX_CTRL_TWO))
      next_ctrl_two = wb_dat_i[7:0] & acc_pkg::CTRL_TWO_WMASK;
    if (wr_lane0 && hit(wb_adr_i, acc_pkg::IDX_CONFIG))
      next_config_r = wb_dat_i[7:0];
    if (wr_lane0 && hit(wb_adr_i, acc_pkg::IDX_IRQ_MASK))
      next_irq_mask = wb_dat_i[1:0];
    if (rd_req) begin
      if (hit(wb_adr_i, acc_pkg::IDX_CTRL_ONE)) next_rdat[7:0] = ctrl_one;
      else if (hit(wb_adr_i, acc_pkg::IDX_CTRL_TWO)) next_rdat[7:0] = ctrl_two;
      else if (hit(wb_adr_i, acc_pkg::IDX_CONFIG)) next_rdat[7:0] = config_r;
      else if (hit(wb_adr_i, acc_pkg::IDX_IRQ_MASK)) next_rdat[1:0] = irq_mask;
      else if (hit(wb_adr_i, acc_pkg::IDX_CORE_ST)) next_rdat[2:0] = 3'(state);
      else if (hit(wb_adr_i, acc_pkg::IDX_IRQ_STAT)) begin
        next_rdat[1:0] = irq_stat;
        next_irq_stat = 2'h0; // read clears
      end
    end
    // busy follows the sequencer
    next_ctrl_one[acc_pkg::BIT_BUSY] = (next_state != acc_pkg::ACC_IDLE);
    // hardware set wins over software clear
    if (core_done_i && state == acc_pkg::ACC_CONV) begin
      next_ctrl_one[acc_pkg::BIT_DONE] = 1'b1;
      next_irq_stat[acc_pkg::IRQ_DONE] = 1'b1;
    end
    if (core_window_hit_i && state == acc_pkg::ACC_CONV) begin
      next_ctrl_one[acc_pkg::BIT_WIN] = 1'b1;
      next_irq_stat[acc_pkg::IRQ_WIN] = 1'b1;
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  // sequencer and SAR clock divider
  always_comb begin
    next_state   = state;
    next_trk_cnt = trk_cnt;
    next_start_q = 1'b0;
    next_sar_en  = 1'b0;
    next_div_cnt = div_cnt;
    if (!conv_on) begin
      next_div_cnt = '0;
    end else if (src_tick) begin
      if (div_cnt >= config_r[acc_pkg::BIT_DIV_LO +: 5]) begin
        next_div_cnt = '0;
        next_sar_en  = 1'b1;
      end else begin
        next_div_cnt = div_cnt + DIV_W'(1);
      end
    end
    case (state)
      acc_pkg::ACC_IDLE: begin
        if (start_ok) begin
          if (config_r[acc_pkg::BIT_TRACK]) begin
            next_state   = acc_pkg::ACC_TRACK;
            next_trk_cnt = 3'(acc_pkg::TRACK_SAR_CYCLES);
          end else begin
            next_state   = acc_pkg::ACC_CONV;
            next_start_q = 1'b1;
          end
        end
      end
      acc_pkg::ACC_TRACK: begin
        if (!conv_on) next_state = acc_pkg::ACC_IDLE;
        else if (sar_en) begin
          next_trk_cnt = trk_cnt - 3'h1;
          if (trk_cnt == 3'h1) begin
            next_state   = acc_pkg::ACC_CONV;
            next_start_q = 1'b1;
          end
        end
      end
      acc_pkg::ACC_CONV: begin
        if (!conv_on || core_done_i) next_state = acc_pkg::ACC_IDLE;
      end
      default: next_state = acc_pkg::ACC_IDLE;
    endcase
    // tracking output registered alongside the state
    next_tracking = (next_state == acc_pkg::ACC_TRACK);
  end

  // registering only
  always_ff @(posedge clk_i) begin
    pin_s1 <= external_start_pin_i;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
    if (rst_i) begin
      ctrl_one <= acc_pkg::RST_CTRL_ONE;
      ctrl_two <= acc_pkg::RST_CTRL_TWO;
      config_r <= acc_pkg::RST_CONFIG;
      irq_mask <= 2'h0;
      irq_stat <= 2'h0;
      ack      <= 1'b0;
      rdat     <= 32'h0000_0000;
      irq      <= 1'b0;
      state    <= acc_pkg::ACC_IDLE;
      div_cnt  <= '0;
      sar_en   <= 1'b0;
      trk_cnt  <= 3'h0;
      start_q  <= 1'b0;
      tracking <= 1'b0;
    end else begin
      ctrl_one <= next_ctrl_one;
      ctrl_two <= next_ctrl_two;
      config_r <= next_config_r;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      ack      <= next_ack;
      rdat     <= next_rdat;
      irq      <= next_irq;
      state    <= next_state;
      div_cnt  <= next_div_cnt;
      sar_en   <= next_sar_en;
      trk_cnt  <= next_trk_cnt;
      start_q  <= next_start_q;
      tracking <= next_tracking;
    end
  end

  // outputs straight from flip-flops
  assign wb_ack_o            = ack;
  assign wb_dat_o            = rdat;
  assign irq_o               = irq;
  assign core_start_o        = start_q;
  assign sar_clk_en_o        = sar_en;
  assign tracking_o          = tracking;
  assign sar_clock_divider_o = config_r[acc_pkg::BIT_DIV_LO +: 5];
  assign core_cfg_o = '{converter_on:          ctrl_one[acc_pkg::BIT_ON],
                        burst_run_enable:      ctrl_one[acc_pkg::BIT_BURST],
                        common_mode_buffer_on: ctrl_two[acc_pkg::BIT_CMB],
                        eight_bit_select:      config_r[acc_pkg::BIT_EIGHT],
                        gain_select:           config_r[acc_pkg::BIT_GAIN],
                        input_clock_hfosc:     ctrl_one[acc_pkg::BIT_BURST]};

  property p_no_start_off;
    @(posedge clk_i) disable iff (rst_i) !conv_on |=> !start_q;
  endproperty
  a_no_start_off: assert property (p_no_start_off) else $error("start while off");

  property p_done_sets;
    @(posedge clk_i) disable iff (rst_i)
      core_done_i && state == acc_pkg::ACC_CONV |=> ctrl_one[acc_pkg::BIT_DONE];
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("done flag not set");

  property p_win_sets;
    @(posedge clk_i) disable iff (rst_i)
      core_window_hit_i && state == acc_pkg::ACC_CONV |=> ctrl_one[acc_pkg::BIT_WIN];
  endproperty
  a_win_sets: assert property (p_win_sets) else $error("window flag not set");

  property p_soft_start;
    @(posedge clk_i) disable iff (rst_i)
      trig && conv_on && state == acc_pkg::ACC_IDLE && !config_r[acc_pkg::BIT_TRACK]
      && ctrl_one[2:0] == acc_pkg::SRC_SOFT |=> start_q;
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("soft start lost");

  property p_reserved_src;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_one[2:0] > acc_pkg::SRC_EXTPIN && state == acc_pkg::ACC_IDLE |=> !start_q;
  endproperty
  a_reserved_src: assert property (p_reserved_src) else $error("reserved source started");

  property p_track_delay;
    @(posedge clk_i) disable iff (rst_i)
      state == acc_pkg::ACC_TRACK && trk_cnt > 3'h1 |=> !start_q;
  endproperty
  a_track_delay: assert property (p_track_delay) else $error("track ended early");

  property p_div_bound;
    @(posedge clk_i) disable iff (rst_i)
      sar_en |-> $past(conv_on) && $past(src_tick)
                 && $past(div_cnt) >= $past(config_r[acc_pkg::BIT_DIV_LO +: 5]);
  endproperty
  a_div_bound: assert property (p_div_bound) else $error("divider wrap wrong");

  property p_cmb_only;
    @(posedge clk_i) disable iff (rst_i) ctrl_two[7:1] == 7'h00;
  endproperty
  a_cmb_only: assert property (p_cmb_only) else $error("reserved bits set");

  property p_off_quiet;
    @(posedge clk_i) disable iff (rst_i) !conv_on |=> !sar_en && state == acc_pkg::ACC_IDLE;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("activity while off");

  property p_burst_tick;
    @(posedge clk_i) disable iff (rst_i)
      burst_on && !hfosc_sar_tick_i |=> !sar_en;
  endproperty
  a_burst_tick: assert property (p_burst_tick) else $error("sar clock off wrong source");

  property p_track_end;
    @(posedge clk_i) disable iff (rst_i)
      state == acc_pkg::ACC_TRACK && conv_on && sar_en && trk_cnt == 3'h1
      |=> start_q && state == acc_pkg::ACC_CONV;
  endproperty
  a_track_end: assert property (p_track_end) else $error("track did not end");
endmodule
`default_nettype wire

// file: verilog/acc_pkg.sv
/*
  acc_pkg: register map, field positions, reset values, start sources and
  shared carriers for the converter control block.
  Assumes a Wishbone classic slave with 32-bit data, one register per word.
*/
package acc_pkg;
  // register indices: the byte address on the bus is four times the index
  localparam logic [7:0] IDX_CTRL_ONE = 8'hE8;
  localparam logic [7:0] IDX_CTRL_TWO = 8'hB2;
  localparam logic [7:0] IDX_CONFIG   = 8'hBC;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hC0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hC1;
  localparam logic [7:0] IDX_CORE_ST  = 8'hC2;

  localparam int BIT_ON      = 7;
  localparam int BIT_BURST   = 6;
  localparam int BIT_DONE    = 5;
  localparam int BIT_BUSY    = 4;
  localparam int BIT_WIN     = 3;
  localparam int BIT_SRC_LO  = 0;
  localparam int BIT_CMB     = 0;
  localparam int BIT_DIV_LO  = 3;
  localparam int BIT_EIGHT   = 2;
  localparam int BIT_TRACK   = 1;
  localparam int BIT_GAIN    = 0;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_WIN     = 1;

  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] RST_CONFIG   = 8'hF8;
  localparam logic [7:0] CTRL_TWO_WMASK = 8'h01;

  localparam logic [2:0] SRC_SOFT   = 3'h0;
  localparam logic [2:0] SRC_TMR0   = 3'h1;
  localparam logic [2:0] SRC_TMR2   = 3'h2;
  localparam logic [2:0] SRC_TMR3   = 3'h3;
  localparam logic [2:0] SRC_EXTPIN = 3'h4;

  localparam int TRACK_SAR_CYCLES = 4;

  typedef enum logic [2:0] {ACC_IDLE, ACC_TRACK, ACC_CONV} acc_state_t;

  // settings driven to the analog core
  typedef struct packed {
    logic       converter_on;
    logic       burst_run_enable;
    logic       common_mode_buffer_on;
    logic       eight_bit_select;
    logic       gain_select;
    logic       input_clock_hfosc;
  } acc_core_cfg_t;
endpackage

// file: testbench/acc_core_model.sv
/* acc_core_model: behavioural analog core and input clock tick source.
   assumes the control block shares clk_i and pulses start for one cycle. */
`timescale 1ns/1ps
`default_nettype none
module acc_core_model #(
  parameter int LAT = 6
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  input  wire logic win_i,
  output logic      sys_tick_o,
  output logic      hf_tick_o,
  output logic      done_o,
  output logic      win_o
);
  int cnt;
  // system clock edge every cycle
  assign sys_tick_o = 1'b1;
  // oscillator edge every other cycle; done after LAT cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt       <= 0;
      hf_tick_o <= 1'b0;
      done_o    <= 1'b0;
      win_o     <= 1'b0;
    end else begin
      hf_tick_o <= ~hf_tick_o;
      done_o    <= (cnt == 1);
      win_o     <= (cnt == 1) && win_i; // window hit only when asked
      if (start_i)
        cnt <= LAT;
      else if (cnt > 0)
        cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/acc_ctrl_tb.sv
/* acc_ctrl_tb: register-level tests of the converter control block.
   assumes acc_core_model stands for the core and the clock ticks. */
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_tb;
  logic        clk_i, rst_i, cyc, stb, we, ack, win_cmd;
  logic        systk, hftk, done, winh, sclk, start, trk, irq;
  logic [3:0]  trig, sel, wsel;
  logic [9:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [4:0]  div;
  acc_pkg::acc_core_cfg_t cfg;
  int          err_total, check_count, n;

  // block under test and its core model
  acc_ctrl acc_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .timer0_ovf_i(trig[0]),
    .timer2_ovf_i(trig[1]), .timer3_ovf_i(trig[2]),
    .external_start_pin_i(trig[3]), .system_clock_source_sar_tick_i(systk),
    .hfosc_sar_tick_i(hftk), .core_done_i(done), .core_window_hit_i(winh),
    .core_cfg_o(cfg), .sar_clock_divider_o(div), .sar_clk_en_o(sclk),
    .core_start_o(start), .tracking_o(trk), .irq_o(irq));
  acc_core_model acc_core_model_inst (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start), .win_i(win_cmd),
    .sys_tick_o(systk), .hf_tick_o(hftk), .done_o(done), .win_o(winh));

  // 50 ns clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] e, input string m);
    check_count++;
    if (got !== e) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, e);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= wsel;
    adr  <= {idx, 2'h0};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) chk(32'h0, 32'h1, "bus timeout");
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] e, input string m);
    wb(1'b0, idx, 8'h00);
    chk(q, {24'h0, e}, m);
  endtask

  task automatic pulse(input logic [3:0] v);
    @(posedge clk_i);
    trig <= v;
    @(posedge clk_i);
    trig <= 4'h0;
  endtask

  // start expected within lo..hi cycles, then let the conversion end
  task automatic wstart(input int lo, input int hi, input string m);
    int k;
    k = 0;
    while (start !== 1'b1 && k < hi) begin
      @(posedge clk_i);
      k++;
    end
    chk({31'h0, start === 1'b1 && k >= lo}, 32'h1, m);
    k = 0;
    while (done !== 1'b1 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    repeat (3) @(posedge clk_i);
  endtask

  // counts sar clock enables (pick 1) or starts (pick 0)
  task automatic count(input logic pick, input int len, input int e, input string m);
    int k;
    k = 0;
    repeat (len) begin
      if ((pick ? sclk : start) === 1'b1) k++;
      @(posedge clk_i);
    end
    chk(k, e, m);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #200000;
    err_total++;
    finish_test();
  end

  // test sequence
  initial begin
    {rst_i, cyc, stb, we, win_cmd} = 5'h10;
    {adr, wdat, trig} = '0;
    {sel, wsel} = 8'hFF;
    err_total = 0;
    check_count = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'hE8, 8'h00, "ctrl one reset");
    rdc(8'hB2, 8'h00, "ctrl two reset");
    rdc(8'hBC, 8'hF8, "config reset");
    rdc(8'h10, 8'h00, "unmapped");
    chk(div, 5'h1F, "divider reset");
    chk(cfg.converter_on, 1'b0, "off");
    $display("test reset done");
    wb(1'b1, 8'hB2, 8'h01);
    rdc(8'hB2, 8'h01, "ctrl two");
    chk(cfg.common_mode_buffer_on, 1'b1, "cm buffer");
    wb(1'b1, 8'hBC, 8'h15);
    rdc(8'hBC, 8'h15, "config");
    chk(div, 5'h02, "divider");
    chk({cfg.eight_bit_select, cfg.gain_select}, 2'h3, "mode gain");
    $display("test config done");
    wb(1'b1, 8'hE8, 8'h10);
    count(1'b0, 10, 0, "start while off");
    count(1'b1, 10, 0, "sar clock while off");
    wb(1'b1, 8'hE8, 8'h80);
    rdc(8'hE8, 8'h80, "on idle");
    count(1'b1, 30, 10, "sar rate sys");
    wb(1'b1, 8'hC1, 8'h03);
    win_cmd <= 1'b1;
    wb(1'b1, 8'hE8, 8'h90);
    chk(cfg.converter_on, 1'b1, "on");
    wstart(0, 3, "soft start");
    chk(irq, 1'b1, "irq raised");
    rdc(8'hE8, 8'hA8, "flags set");
    rdc(8'hC0, 8'h03, "irq status");
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0, "irq cleared");
    wb(1'b1, 8'hE8, 8'h80);
    rdc(8'hE8, 8'h80, "flags cleared");
    wb(1'b1, 8'hC1, 8'h00);
    win_cmd <= 1'b0;
    $display("test soft start done");
    for (n = 1; n <= 5; n++) begin
      wb(1'b1, 8'hE8, 8'h80 | 8'(n));
      pulse(n < 5 ? 4'hF ^ (4'h1 << (n - 1)) : 4'hF);
      count(1'b0, 10, 0, "wrong source");
      if (n < 5) begin
        pulse(4'h1 << (n - 1));
        wstart(0, 8, "source start");
        chk(irq, 1'b0, "irq masked");
        rdc(8'hE8, 8'hA0 | 8'(n), "done flag");
        rdc(8'hC0, 8'h01, "status done");
      end
    end
    $display("test sources done");
    wb(1'b1, 8'hBC, 8'h12);
    rdc(8'hBC, 8'h12, "config track");
    chk({cfg.eight_bit_select, cfg.gain_select}, 2'h0, "mode gain");
    wb(1'b1, 8'hE8, 8'h80);
    wb(1'b1, 8'hE8, 8'h90);
    @(posedge clk_i);
    chk(trk, 1'b1, "tracking");
    wstart(9, 11, "delayed start");
    $display("test track done");
    wb(1'b1, 8'hE8, 8'hC0);
    rdc(8'hE8, 8'hC0, "burst on");
    chk({cfg.burst_run_enable, cfg.input_clock_hfosc}, 2'h3, "burst");
    count(1'b1, 30, 5, "sar rate osc");
    wsel = 4'hE;
    wb(1'b1, 8'hBC, 8'h00);
    wsel = 4'hF;
    rdc(8'hBC, 8'h12, "lane 0 off");
    $display("test burst done");
    finish_test();
  end
endmodule
`default_nettype wire
